// *** rtl/dwb_pkg.sv ***
// Shared constants, types and latency helper for the write burst link
package dwb_pkg;

  // Depth of the write latency pipeline, one entry per clock
  localparam int MAX_WL = 32;

  // Burst-length field codes of mode_register_zero
  localparam logic [1:0] BL_FIX8 = 2'h0;  // burst_eight always
  localparam logic [1:0] BL_OTF  = 2'h1;  // on_the_fly per command
  localparam logic [1:0] BL_FIX4 = 2'h2;  // burst_chop_four always

  // Additive latency selections
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CL1  = 2'h1;
  localparam logic [1:0] AL_CL2  = 2'h2;

  // Latency bases added to the programmed offsets; ODT_LEAD is subtracted
  localparam logic [5:0] CL_BASE  = 6'h05;
  localparam logic [5:0] CWL_BASE = 6'h05;
  localparam logic [5:0] ODT_LEAD = 6'h01;

  // Clock slots taken by one burst on the data pins
  localparam logic [2:0] SLOT_FULL = 3'h4;
  localparam logic [2:0] SLOT_CHOP = 3'h2;

  // Field positions in the mode-set address
  localparam int MR_BL_LSB  = 0;
  localparam int MR_AL_LSB  = 2;
  localparam int MR_CWL_LSB = 4;
  localparam int MR_CL_LSB  = 7;
  localparam int ADDR_W     = 11;

  // Controller register offsets and command fields
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_MODE   = 8'h08;
  localparam logic [7:0] REG_TIMING = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_CHOP_BIT = 2;
  localparam int CMD_BANK_LSB = 3;
  localparam logic [1:0] OP_WR  = 2'h0;
  localparam logic [1:0] OP_RD  = 2'h1;
  localparam logic [1:0] OP_PRE = 2'h2;
  localparam logic [1:0] OP_MRS = 2'h3;
  localparam logic [7:0] TWR_RST  = 8'h06;
  localparam logic [7:0] WRITE_TO_READ_TIME_RST = 8'h04;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_WR  = 3'h1,
    CMD_RD  = 3'h2,
    CMD_PRE = 3'h3,
    CMD_MRS = 3'h4
  } dwb_cmd_type;

  // Additive latency plus CAS write latency
  function automatic logic [5:0] dwb_write_latency(
    input logic [1:0] al_sel,
    input logic [3:0] cl_off,
    input logic [2:0] cwl_off
  );
    logic [5:0] cl;
    logic [5:0] al;
    cl = CL_BASE + {2'h0, cl_off};
    case (al_sel)
      AL_CL1:  al = cl - 6'h01;
      AL_CL2:  al = cl - 6'h02;
      default: al = 6'h00;
    endcase
    return al + CWL_BASE + {3'h0, cwl_off};
  endfunction

endpackage

// *** rtl/dwb_link_if.sv ***
// Command, data and strobe link between controller and DRAM end
`timescale 1ns/1ps
`default_nettype none
interface dwb_link_if (
  input wire logic ref_clk  // Shared command clock
);
  dwb_pkg::dwb_cmd_type cmd;
  logic                 chop_select_bit;
  logic [2:0]           bank;
  logic [10:0]          addr;
  logic [15:0]          dq;
  logic                 dqs;
  logic                 dqs_en;

  modport ctrl (output cmd, chop_select_bit, bank, addr, dq, dqs, dqs_en);
  modport dram (input cmd, chop_select_bit, bank, addr, dq, dqs, dqs_en);
endinterface
`default_nettype wire

// *** rtl/dwb_burst_sel.sv ***
// Burst length choice from mode field and per-command chop bit
`timescale 1ns/1ps
`default_nettype none
module dwb_burst_sel (
  input  wire logic [1:0] bl_mode,     // Burst-length field
  input  wire logic       chop_bit,    // Chop select of the command
  output logic            chop,        // Burst is chopped to four
  output logic            short_slot   // Burst frees pins after 2 clocks
);
  // Fixed codes never look at the chop bit
  always_comb begin
    unique case (bl_mode)
      dwb_pkg::BL_OTF:  chop = !chop_bit;
      dwb_pkg::BL_FIX4: chop = 1'b1;
      default:          chop = 1'b0;
    endcase
    short_slot = (bl_mode == dwb_pkg::BL_FIX4);
  end
endmodule
`default_nettype wire

// *** rtl/dwb_dram_end.sv ***
// DRAM end: mode decode, write latency pipeline and burst capture
`timescale 1ns/1ps
`default_nettype none
// What this block and the controller end together do
// - Fixed-eight, or on-the-fly with bit high: eight
// - On-the-fly with chop bit low: chop four
// - Fixed chop-four mode chops every write
// - Write latency is additive plus CAS write
// - No precharge before write recovery elapses
// - On-the-fly chop recovery counted as eight
// - Turnaround counted after final write data
// - Strobe aligned at every rising edge
// - Read burst length from its own bit
// - Mixed lengths four clocks apart are honoured; the controller end refuses any command until the earlier burst ends
// - Termination transition is latency minus one
module dwb_dram_end #(
  parameter int MAX_WL = dwb_pkg::MAX_WL  // Deepest write latency held
) (
  input  wire logic        ref_clk,         // Command clock
  input  wire logic        rst_b,           // Synchronous reset, low
  dwb_link_if.dram         link,            // Link from the controller
  output logic             wr_valid,        // Write beat pair captured
  output logic [15:0]      wr_data,         // Captured beat pair
  output logic [2:0]       wr_bank,         // Bank of the burst
  output logic [2:0]       wr_beat,         // Clock index within burst
  output logic             wr_ref,          // Recovery reference edge
  output logic             rd_start,        // Read command seen
  output logic             rd_chop,         // Read burst is chopped
  output logic [2:0]       rd_bank,         // Bank of the read
  output logic [1:0]       burst_mode,      // Current burst field
  output logic [5:0]       write_latency,   // Current write latency
  output logic [5:0]       odt_transition,  // Sync to async period
  output logic             strobe_fault     // Strobe missing on a beat
);

  typedef struct packed {
    logic [1:0]              bl_mode;
    logic [1:0]              al_sel;
    logic [3:0]              cl_off;
    logic [2:0]              cwl_off;
    logic [MAX_WL-1:0]       pv;
    logic [MAX_WL-1:0]       pc;
    logic [MAX_WL-1:0]       ps;
    logic [MAX_WL-1:0][2:0]  pb;
    logic [2:0]              slot;
    logic [2:0]              beat;
    logic                    chop;
    logic [2:0]              bank;
    logic                    wr_valid;
    logic [15:0]             wr_data;
    logic [2:0]              wr_bank;
    logic [2:0]              wr_beat;
    logic                    wr_ref;
    logic                    rd_start;
    logic                    rd_chop;
    logic [2:0]              rd_bank;
    logic [5:0]              wl;
    logic [5:0]              odt;
    logic                    fault;
  } dwb_dram_state_type;

  dwb_dram_state_type state_reg;
  dwb_dram_state_type state_next;
  logic               cmd_chop;
  logic               cmd_short;
  logic [5:0]         wl_now;

  // One selector serves reads and writes; only one command per clock
  dwb_burst_sel u_sel (
    .bl_mode    (state_reg.bl_mode),
    .chop_bit   (link.chop_select_bit),
    .chop       (cmd_chop),
    .short_slot (cmd_short)
  );

  // Latency follows the last mode set at once
  assign wl_now = dwb_pkg::dwb_write_latency(state_reg.al_sel,
                                             state_reg.cl_off,
                                             state_reg.cwl_off);

  // Next state: command decode, latency line and beat capture
  always_comb begin
    int  idx;
    logic data_clk;
    logic [2:0] slot_len;
    idx        = 0;
    data_clk   = 1'b0;
    slot_len   = dwb_pkg::SLOT_FULL;
    state_next = state_reg;
    state_next.wr_valid = 1'b0;
    state_next.wr_ref   = 1'b0;
    state_next.rd_start = 1'b0;

    // Latency line moves one clock nearer the data pins
    state_next.pv = state_reg.pv >> 1;
    state_next.pc = state_reg.pc >> 1;
    state_next.ps = state_reg.ps >> 1;
    state_next.pb = {3'h0, state_reg.pb[MAX_WL-1:1]};

    // Each write takes its own slot so mixed lengths overlap cleanly
    unique case (link.cmd)
      dwb_pkg::CMD_WR: begin
        idx = int'(wl_now) - 1;
        state_next.pv[idx] = 1'b1;
        state_next.pc[idx] = cmd_chop;
        state_next.ps[idx] = cmd_short;
        state_next.pb[idx] = link.bank;
      end
      dwb_pkg::CMD_RD: begin
        state_next.rd_start = 1'b1;
        state_next.rd_chop  = cmd_chop;
        state_next.rd_bank  = link.bank;
      end
      dwb_pkg::CMD_MRS: begin
        state_next.bl_mode = link.addr[dwb_pkg::MR_BL_LSB +: 2];
        state_next.al_sel  = link.addr[dwb_pkg::MR_AL_LSB +: 2];
        state_next.cwl_off = link.addr[dwb_pkg::MR_CWL_LSB +: 3];
        state_next.cl_off  = link.addr[dwb_pkg::MR_CL_LSB +: 4];
      end
      default: begin
      end
    endcase

    // First data clock of a burst overrides any slot still running
    if (state_reg.pv[0]) begin
      slot_len = state_reg.ps[0] ? dwb_pkg::SLOT_CHOP
                                 : dwb_pkg::SLOT_FULL;
      data_clk = 1'b1;
      state_next.slot    = slot_len - 3'h1;
      state_next.beat    = 3'h1;
      state_next.chop    = state_reg.pc[0];
      state_next.bank    = state_reg.pb[0];
      state_next.wr_bank = state_reg.pb[0];
      state_next.wr_beat = 3'h0;
    end else if (state_reg.slot != 3'h0) begin
      data_clk = !state_reg.chop || (state_reg.beat < 3'h2);
      state_next.slot    = state_reg.slot - 3'h1;
      state_next.beat    = state_reg.beat + 3'h1;
      state_next.wr_bank = state_reg.bank;
      state_next.wr_beat = state_reg.beat;
      // An on-the-fly chop still runs four clocks before the reference
      state_next.wr_ref  = (state_reg.slot == 3'h1);
    end

    if (data_clk) begin
      state_next.wr_valid = 1'b1;
      state_next.wr_data  = link.dq;
      // Strobe must stand at this edge, not only at the first
      if (!(link.dqs_en && link.dqs)) begin
        state_next.fault = 1'b1;
      end
    end

    state_next.wl  = wl_now;
    state_next.odt = wl_now - dwb_pkg::ODT_LEAD;
  end

  // All-zero reset gives fixed eight, no additive latency, base CAS_WRITE_LATENCY
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wr_valid       = state_reg.wr_valid;
  assign wr_data        = state_reg.wr_data;
  assign wr_bank        = state_reg.wr_bank;
  assign wr_beat        = state_reg.wr_beat;
  assign wr_ref         = state_reg.wr_ref;
  assign rd_start       = state_reg.rd_start;
  assign rd_chop        = state_reg.rd_chop;
  assign rd_bank        = state_reg.rd_bank;
  assign burst_mode     = state_reg.bl_mode;
  assign write_latency  = state_reg.wl;
  assign odt_transition = state_reg.odt;
  assign strobe_fault   = state_reg.fault;

endmodule
`default_nettype wire

// *** rtl/dwb_ctrl_end.sv ***
// Controller end: AXI4-Lite registers, command issue and interval guard
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dwb_ctrl_end (
  input  wire logic        ref_clk,        // Command clock
  input  wire logic        rst_b,          // Synchronous reset, low
  dwb_link_if.ctrl         link,           // Link to the DRAM end
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [7:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Byte enables
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  output logic [1:0]       s_axi_bresp,    // Write response
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  input  wire logic [7:0]  s_axi_araddr,   // Read address
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready,   // Read data ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp     // Read response
);

  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_LAT  = 3'b010,
    C_DATA = 3'b100
  } dwb_ctrl_fsm_type;

  typedef struct packed {
    dwb_ctrl_fsm_type     st;
    logic                 aw_have;
    logic [7:0]           aw_addr;
    logic                 w_have;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [31:0]          wdata;
    logic [10:0]          mode;
    logic [7:0]           write_recovery_time;
    logic [7:0]           write_to_read_time;
    logic                 refused;
    logic [5:0]           cnt;
    logic [2:0]           beat;
    logic [2:0]           slot;
    logic                 chop;
    logic [7:0]           wr_cnt;
    logic [7:0]           wtr_cnt;
    dwb_pkg::dwb_cmd_type cmd;
    logic                 chop_bit;
    logic [2:0]           bank;
    logic [10:0]          addr;
    logic [15:0]          dq;
    logic                 dqs;
  } dwb_ctrl_state_type;

  dwb_ctrl_state_type s_reg;
  dwb_ctrl_state_type s_next;
  logic               new_chop;
  logic               new_short;
  logic [5:0]         wl_now;

  // Mapped offsets, shared by the read and write paths
  function automatic logic dwb_mapped(input logic [7:0] a);
    return a == dwb_pkg::REG_CMD || a == dwb_pkg::REG_WDATA ||
           a == dwb_pkg::REG_MODE || a == dwb_pkg::REG_TIMING ||
           a == dwb_pkg::REG_STATUS;
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] dwb_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] v;
    v = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return v;
  endfunction

  // Same choice the DRAM end makes, so both agree on the slot
  dwb_burst_sel u_sel (
    .bl_mode    (s_reg.mode[dwb_pkg::MR_BL_LSB +: 2]),
    .chop_bit   (s_reg.w_data[dwb_pkg::CMD_CHOP_BIT]),
    .chop       (new_chop),
    .short_slot (new_short)
  );

  assign wl_now = dwb_pkg::dwb_write_latency(
                    s_reg.mode[dwb_pkg::MR_AL_LSB +: 2],
                    s_reg.mode[dwb_pkg::MR_CL_LSB +: 4],
                    s_reg.mode[dwb_pkg::MR_CWL_LSB +: 3]);

  // Next state: bus slave, command issue, data drive and guards
  always_comb begin
    logic [31:0] v;
    logic [1:0]  op;
    logic        idle;
    v      = 32'h0000_0000;
    op     = s_reg.w_data[dwb_pkg::CMD_OP_LSB +: 2];
    idle   = (s_reg.st == C_IDLE);
    s_next = s_reg;
    s_next.cmd = dwb_pkg::CMD_NOP;
    if (s_reg.wr_cnt != 8'h00) s_next.wr_cnt = s_reg.wr_cnt - 8'h01;
    if (s_reg.wtr_cnt != 8'h00) s_next.wtr_cnt = s_reg.wtr_cnt - 8'h01;

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_have = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) s_next.bvalid = 1'b0;

    if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
      s_next.aw_have = 1'b0;
      s_next.w_have  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = dwb_mapped(s_reg.aw_addr) ? dwb_pkg::RESP_OKAY
                                                 : dwb_pkg::RESP_SLVERR;
      unique case (s_reg.aw_addr)
        dwb_pkg::REG_WDATA:
          s_next.wdata = dwb_merge(s_reg.wdata, s_reg.w_data,
                                   s_reg.w_strb);
        dwb_pkg::REG_MODE: begin
          v = dwb_merge({21'h0, s_reg.mode}, s_reg.w_data, s_reg.w_strb);
          s_next.mode = v[10:0];
        end
        dwb_pkg::REG_TIMING: begin
          v = dwb_merge({16'h0, s_reg.write_to_read_time, s_reg.write_recovery_time}, s_reg.w_data,
                        s_reg.w_strb);
          s_next.write_recovery_time  = v[7:0];
          s_next.write_to_read_time = v[15:8];
        end
        dwb_pkg::REG_CMD: begin
          s_next.chop_bit = s_reg.w_data[dwb_pkg::CMD_CHOP_BIT];
          s_next.bank     = s_reg.w_data[dwb_pkg::CMD_BANK_LSB +: 3];
          s_next.addr     = s_reg.mode;
          s_next.refused  = 1'b0;
          // Refused orders leave the link idle and raise the flag
          if (!idle) begin
            s_next.refused = 1'b1;
          end else if (op == dwb_pkg::OP_WR) begin
            s_next.cmd  = dwb_pkg::CMD_WR;
            s_next.st   = C_LAT;
            s_next.cnt  = wl_now - 6'h01;
            s_next.chop = new_chop;
            s_next.slot = new_short ? dwb_pkg::SLOT_CHOP
                                    : dwb_pkg::SLOT_FULL;
          end else if (op == dwb_pkg::OP_PRE) begin
            if (s_reg.wr_cnt != 8'h00) s_next.refused = 1'b1;
            else s_next.cmd = dwb_pkg::CMD_PRE;
          end else if (op == dwb_pkg::OP_RD) begin
            if (s_reg.wtr_cnt != 8'h00) s_next.refused = 1'b1;
            else s_next.cmd = dwb_pkg::CMD_RD;
          end else begin
            s_next.cmd = dwb_pkg::CMD_MRS;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads answer one clock after the address is taken
    if (s_axi_rvalid && s_axi_rready) s_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = dwb_mapped(s_axi_araddr) ? dwb_pkg::RESP_OKAY
                                               : dwb_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        dwb_pkg::REG_WDATA:  s_next.rdata = s_reg.wdata;
        dwb_pkg::REG_MODE:   s_next.rdata = {21'h0, s_reg.mode};
        dwb_pkg::REG_TIMING: s_next.rdata = {16'h0, s_reg.write_to_read_time, s_reg.write_recovery_time};
        dwb_pkg::REG_STATUS:
          s_next.rdata = {26'h0, wl_now[5:4], s_reg.refused,
                          s_reg.wtr_cnt != 8'h00, s_reg.wr_cnt != 8'h00,
                          !idle};
        default:             s_next.rdata = 32'h0000_0000;
      endcase
    end
    s_next.awready = !s_next.aw_have && !s_next.bvalid;
    s_next.wready  = !s_next.w_have && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;

    // Data clocks: strobe raised at every edge that carries a beat
    s_next.dqs = 1'b0;
    unique case (s_reg.st)
      C_LAT: begin
        if (s_reg.cnt == 6'h00) begin
          s_next.st   = C_DATA;
          s_next.beat = 3'h1;
          s_next.dq   = s_reg.wdata[15:0];
          s_next.dqs  = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - 6'h01;
        end
      end
      C_DATA: begin
        if (s_reg.beat == s_reg.slot) begin
          // Edge after the slot's last clock starts both intervals
          s_next.st      = C_IDLE;
          s_next.wr_cnt  = s_reg.write_recovery_time;
          s_next.wtr_cnt = s_reg.write_to_read_time;
        end else begin
          s_next.beat = s_reg.beat + 3'h1;
          s_next.dq   = s_reg.beat[0] ? s_reg.wdata[31:16]
                                      : s_reg.wdata[15:0];
          s_next.dqs  = !s_reg.chop || (s_reg.beat < 3'h2);
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_reg      <= '0;
      s_reg.st   <= C_IDLE;
      s_reg.write_recovery_time  <= dwb_pkg::TWR_RST;
      s_reg.write_to_read_time <= dwb_pkg::WRITE_TO_READ_TIME_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.cmd             = s_reg.cmd;
  assign link.chop_select_bit = s_reg.chop_bit;
  assign link.bank            = s_reg.bank;
  assign link.addr            = s_reg.addr;
  assign link.dq              = s_reg.dq;
  assign link.dqs             = s_reg.dqs;
  assign link.dqs_en          = s_reg.dqs;
  assign s_axi_awready        = s_reg.awready;
  assign s_axi_wready         = s_reg.wready;
  assign s_axi_bvalid         = s_reg.bvalid;
  assign s_axi_bresp          = s_reg.bresp;
  assign s_axi_arready        = s_reg.arready;
  assign s_axi_rvalid         = s_reg.rvalid;
  assign s_axi_rdata          = s_reg.rdata;
  assign s_axi_rresp          = s_reg.rresp;

endmodule
`default_nettype wire

// *** sim/dwb_link_monitor.sv ***
// Link checker for burst shape and command spacing
`timescale 1ns/1ps
`default_nettype none
module dwb_link_monitor (
  input wire logic                 ref_clk,          // Command clock
  input wire logic                 rst_b,            // Sync reset, low
  input var  dwb_pkg::dwb_cmd_type cmd,              // Link command
  input wire logic                 chop_select_bit,  // Chop select
  input wire logic [2:0]           bank,             // Bank
  input wire logic [10:0]          addr,             // Mode word
  input wire logic [15:0]          dq,               // Data
  input wire logic                 dqs,              // Strobe
  input wire logic                 dqs_en            // Strobe enable
);
  logic [1:0] bl_reg;   // Burst field of the last mode set
  logic       wl5_reg;  // Latency still five, so fixed delays apply

  // Shadow of the mode word; other latencies are left to the bench
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bl_reg  <= dwb_pkg::BL_FIX8;
      wl5_reg <= 1'b1;
    end else if (cmd == dwb_pkg::CMD_MRS) begin
      bl_reg  <= addr[1:0];
      wl5_reg <= addr[6:2] == 5'h00;
    end
  end

  wire logic wr_go  = cmd == dwb_pkg::CMD_WR && wl5_reg;
  wire logic is_otf = bl_reg == dwb_pkg::BL_OTF;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence full_slot; dqs [*4] ##1 !dqs; endsequence
  sequence chop_slot; dqs [*2] ##1 !dqs; endsequence

  chk_strobe_pair: assert property (dqs_en == dqs)
    else $error("strobe enable differs from strobe");
  chk_eight_burst: assert property (
    wr_go && (bl_reg == dwb_pkg::BL_FIX8 || is_otf && chop_select_bit)
    |-> ##5 full_slot) else $error("eight beat burst malformed");
  chk_otf_chop: assert property (
    wr_go && is_otf && !chop_select_bit |-> ##5 chop_slot)
    else $error("on the fly chop malformed");
  chk_fixed_chop: assert property (
    wr_go && bl_reg == dwb_pkg::BL_FIX4 |-> ##5 chop_slot)
    else $error("fixed chop malformed");
  chk_write_gap: assert property (
    cmd == dwb_pkg::CMD_WR |=> (cmd == dwb_pkg::CMD_NOP) [*4])
    else $error("command too soon after write");
  chk_pre_recovery: assert property (
    $fell(dqs) |-> (cmd != dwb_pkg::CMD_PRE) [*6])
    else $error("precharge inside write recovery");
  chk_otf_recovery: assert property (
    wr_go && is_otf && !chop_select_bit
    |-> ##7 (cmd != dwb_pkg::CMD_PRE) [*8])
    else $error("chop recovery not counted as eight");
  chk_read_turn: assert property (
    $fell(dqs) |-> (cmd != dwb_pkg::CMD_RD) [*4])
    else $error("read inside write turnaround");
endmodule
`default_nettype wire

// *** sim/tb_dram_write_burst_timing.sv ***
// Self-checking bench for both ends of the write burst link
`timescale 1ns/1ps
`default_nettype none
module tb_dram_write_burst_timing;
  logic        ref_clk, rst_b, awv, awrdy, wv, wrdy, bv, arv, arrdy, rv;
  logic        wr_valid, rd_chop, fault;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [1:0]  bresp, rresp, bm;
  logic [15:0] wr_data, beat0;
  logic [2:0]  wr_beat, rd_bank, wb, bank0;
  logic [5:0]  wl, odt;
  int          num_errors, cmp_count, beats;

  // Free running clock at the command rate
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  dwb_link_if dwb_link_if_i (.ref_clk(ref_clk));
  dwb_ctrl_end dwb_ctrl_end_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(dwb_link_if_i), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arrdy), .s_axi_araddr(araddr), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  dwb_dram_end dwb_dram_end_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(dwb_link_if_i), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_bank(wb), .wr_beat(wr_beat), .wr_ref(), .rd_start(),
    .rd_chop(rd_chop), .rd_bank(rd_bank), .burst_mode(bm),
    .write_latency(wl), .odt_transition(odt), .strobe_fault(fault));
  dwb_link_monitor dwb_link_monitor_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .cmd(dwb_link_if_i.cmd), .chop_select_bit(dwb_link_if_i.chop_select_bit),
    .bank(dwb_link_if_i.bank), .addr(dwb_link_if_i.addr),
    .dq(dwb_link_if_i.dq), .dqs(dwb_link_if_i.dqs),
    .dqs_en(dwb_link_if_i.dqs_en));

  // Count captured data clocks; the first one's data is kept
  always @(posedge ref_clk) if (wr_valid === 1'b1) begin
    beats <= beats + 1;
    if (wr_beat === 3'h0) {bank0, beat0} <= {wb, wr_data};
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Additive plus CAS write latency, worked out independently
  function automatic logic [31:0] exp_wl(input int al, cl, cas_write_latency);
    return ((al == 0) ? 0 : 32'h5 + cl - al) + 32'h5 + cas_write_latency;
  endfunction
  function automatic logic chopped(input logic [1:0] m, input logic c);
    return m == dwb_pkg::BL_FIX4 || (m == dwb_pkg::BL_OTF && !c);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awv <= 1'b1;
    wv <= 1'b1;
    awaddr <= a;
    wdata <= d;
    do begin
      @(posedge ref_clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    arv <= 1'b1;
    araddr <= a;
    do begin
      @(posedge ref_clk);
      if (arrdy) arv <= 1'b0;
    end while (!rv);
    d = rdata;
    r = rresp;
  endtask
  task automatic mode(input logic [1:0] bl, al, input logic [3:0] cl,
                      input logic [2:0] cas_write_latency);
    wr(dwb_pkg::REG_MODE, {21'h0, cl, cas_write_latency, al, bl});
    wr(dwb_pkg::REG_CMD, {30'h0, dwb_pkg::OP_MRS});
    cyc(3);
  endtask
  task automatic finish_test;
    $display("Compares %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    cyc(20000);
    num_errors++;
    finish_test;
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r, m;
    logic [2:0]  bk;
    int          b0;
    {rst_b, awv, wv, arv, awaddr, araddr, wdata, beats} = '0;
    seed = 32'h0001343C;
    cyc(4);
    rst_b <= 1'b1;
    cyc(2);
    chk(wl, 32'h5);
    chk(odt, 32'h4);
    rd(8'h14, d, r);
    chk(r, dwb_pkg::RESP_SLVERR);
    // Every burst field with both chop values; early precharge refused
    for (int i = 0; i < 6; i++) begin
      m = 2'(i / 2);
      seed = lfsr(seed);
      bk = seed[5:3];
      mode(m, dwb_pkg::AL_ZERO, 4'h0, 3'h0);
      b0 = beats;
      wr(dwb_pkg::REG_WDATA, seed);
      wr(dwb_pkg::REG_CMD, {26'h0, bk, i[0], dwb_pkg::OP_WR});
      cyc(7);
      wr(dwb_pkg::REG_CMD, {30'h0, dwb_pkg::OP_PRE});
      rd(dwb_pkg::REG_STATUS, d, r);
      chk(d[3], 1'b1);
      cyc(25);
      chk(beats - b0, chopped(m, i[0]) ? 2 : 4);
      chk(beat0, seed[15:0]);
      chk(bank0, bk);
      chk(bm, m);
      seed = lfsr(seed);
      wr(dwb_pkg::REG_CMD, {26'h0, bk, seed[0], dwb_pkg::OP_RD});
      cyc(3);
      chk(rd_chop, chopped(m, seed[0]));
      chk(rd_bank, bk);
    end
    mode(dwb_pkg::BL_FIX8, dwb_pkg::AL_CL1, 4'h0, 3'h0);
    chk(wl, 32'h9);
    // Each additive choice with random CAS offsets
    for (int a = 0; a < 3; a++) begin
      seed = lfsr(seed);
      mode(dwb_pkg::BL_OTF, 2'(a), seed[3:0], seed[6:4]);
      chk(wl, exp_wl(a, seed[3:0], seed[6:4]));
      chk(odt, exp_wl(a, seed[3:0], seed[6:4]) - 1);
    end
    chk(fault, 1'b0);
    finish_test;
  end
endmodule
`default_nettype wire
